// ===== verilog/urm_pkg.sv
// constants, register map and state encodings of one uart channel
// Operation
// - general bank reachable only while line format bit 7 is clear
// - divisor low and high bytes reachable only while line format bit 7 is set
// - enhanced control and flow characters reachable only while line format holds BFh
// - enhanced-function bits keep their value unless enhanced enable bit 4 is set
// - receive shift register assembles serial characters into a 64-entry receive fifo
// - receive framing follows the line format word length and parity settings; only one stop bit is checked
// - fifos disabled: received characters land in entry zero, overwriting
// - receive fifo full: new characters are dropped, receiver never stalls
// - each character carries its break, framing and parity status
// - written bytes queue in a 64-entry transmit fifo feeding the shifter
// - fifos disabled: transmit bytes still pass through fifo storage
// - transmit bytes written while storage is full are dropped
// - fifo control bit 0 enables both fifos; disabled after reset
// - transmission control and trigger level need enhanced enable and modem bit 6
// - fifo ready summary readable only with modem bit 2 set, loopback off
package urm_pkg;
  localparam int             FIFO_DEPTH  = 64;
  localparam int             PTR_W       = 6;
  localparam int             CNT_W       = 7;
  localparam logic [6:0]     FIFO_FULL   = 7'h40;
  localparam int             RX_W        = 11;
  localparam int             TICK_W      = 21;
  localparam logic [7:0]     LCR_ENH_KEY = 8'hBF;
  localparam logic [7:0]     REG_RST     = 8'h00;
  localparam logic [15:0]    DIV_MIN     = 16'h0001;
  localparam logic [3:0]     IIR_NONE    = 4'h1;
  localparam logic [7:0]     IER_ENH     = 8'hF0;
  localparam logic [7:0]     MCR_ENH     = 8'hE0;
  localparam logic [7:0]     FCR_ENH     = 8'h30;
  localparam int             LCR_DLAB    = 7;
  localparam int             LCR_BREAK   = 6;
  localparam int             LCR_STICK   = 5;
  localparam int             LCR_EVEN    = 4;
  localparam int             LCR_PAR     = 3;
  localparam int             LCR_STOP    = 2;
  localparam int             EFR_ENH     = 4;
  localparam int             MCR_TCR     = 6;
  localparam int             MCR_LOOP    = 4;
  localparam int             MCR_RDY     = 2;
  localparam int             FCR_EN      = 0;
  localparam int             FCR_RX_RST  = 1;
  localparam int             FCR_TX_RST  = 2;
  localparam logic [2:0]     ADR_HOLD    = 3'h0;
  localparam logic [2:0]     ADR_IER     = 3'h1;
  localparam logic [2:0]     ADR_FIFO    = 3'h2;
  localparam logic [2:0]     ADR_LCR     = 3'h3;
  localparam logic [2:0]     ADR_MCR     = 3'h4;
  localparam logic [2:0]     ADR_LSR     = 3'h5;
  localparam logic [2:0]     ADR_MSR     = 3'h6;
  localparam logic [2:0]     ADR_SPR     = 3'h7;

  typedef enum logic [4:0] {
    SEL_NONE, SEL_HOLD, SEL_IER, SEL_FIFO, SEL_LCR, SEL_MCR, SEL_LSR, SEL_MSR, SEL_SPR,
    SEL_TCR, SEL_TLR, SEL_RDY, SEL_DLL, SEL_DLH, SEL_EFR, SEL_RESUME_CHAR_ONE, SEL_RESUME_CHAR_TWO, SEL_PAUSE_CHAR_ONE,
    SEL_PAUSE_CHAR_TWO
  } urm_sel_t;

  typedef enum logic [2:0] {
    SER_IDLE   = 3'h0,
    SER_START  = 3'h1,
    SER_DATA   = 3'h3,
    SER_PARITY = 3'h2,
    SER_STOP   = 3'h6
  } urm_ser_t;
endpackage : urm_pkg

// ===== verilog/urm_fifo.sv
// 64-entry holding fifo with single-entry mode
module urm_fifo
  import urm_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic             single,
  input  wire logic             overwrite,
  input  wire logic             push,
  input  wire logic [W-1:0]     push_data,
  input  wire logic             pop,
  output logic      [W-1:0]     pop_data,
  output logic                  empty,
  output logic                  full,
  output logic      [CNT_W-1:0] count
);
  logic [W-1:0]     mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic             do_push;
  logic             do_pop;
  logic             grow;

  assign empty    = (count == '0);
  assign full     = single ? !empty : (count == FIFO_FULL);
  assign do_pop   = pop && !empty && !flush;
  assign do_push  = push && !flush && (!full || (single && overwrite));
  assign grow     = do_push && (!full || do_pop);
  assign pop_data = mem[rd_ptr];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= single ? '0 : PTR_W'(wr_ptr + 1'b1);
      if (do_pop) rd_ptr <= single ? '0 : PTR_W'(rd_ptr + 1'b1);
      count <= CNT_W'(count + {6'h00, grow} - {6'h00, do_pop});
    end
  end

  always_ff @(posedge mclk) begin
    if (do_push) mem[wr_ptr] <= push_data;
  end
endmodule : urm_fifo

// ===== verilog/urm_skid.sv
// two-entry buffer between transmit fifo and shifter
module urm_skid
  import urm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic      [7:0] out_data
);
  logic [7:0] slot0;
  logic [7:0] slot1;
  logic [1:0] fill;
  logic       take;
  logic       give;

  assign in_ready  = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data  = slot0;
  assign take      = in_valid && in_ready;
  assign give      = out_valid && out_ready;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      slot0 <= 8'h00;
      slot1 <= 8'h00;
      fill  <= 2'h0;
    end else begin
      case ({take, give})
        2'b10: begin
          if (fill == 2'h0) slot0 <= in_data;
          else slot1 <= in_data;
          fill <= 2'(fill + 2'h1);
        end
        2'b01: begin
          slot0 <= slot1;
          fill  <= 2'(fill - 2'h1);
        end
        2'b11: begin
          slot0 <= (fill == 2'h1) ? in_data : slot1;
          slot1 <= in_data;
        end
        default: begin
        end
      endcase
    end
  end
endmodule : urm_skid

// ===== verilog/urm_top.sv
// one uart channel: banked register map, holding fifos and shifters
module urm_top
  import urm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  input  wire logic       rx_pin,
  output logic            tx_pin
);
  logic [7:0]        line_format_control, ier, fifo_control, modem_control, spr, transmission_control, trigger_level, dll, divisor_high_byte, enhanced_feature_control;
  logic [7:0]        resume_char_one, resume_char_two, pause_char_one, pause_char_two, rd_val, lsr_val;
  logic              rd_prev, wr_prev, rd_act, wr_act, rd_go, wr_go, enh_en;
  urm_sel_t          sel;
  logic [RX_W-1:0]   rx_word, rx_top;
  logic              rx_push, rx_pop, rx_empty, rx_full, rx_flush, overrun;
  logic [CNT_W-1:0]  rx_count, tx_count;
  logic              tx_push, tx_pop, tx_empty, tx_full, tx_flush;
  logic [7:0]        tx_fifo_data, sk_data;
  logic              sk_in_ready, sk_valid, sk_ready;
  urm_ser_t          rx_state, tx_state;
  logic [TICK_W-1:0] rx_tick, tx_tick, bit_len, half_len, stop_len;
  logic [2:0]        rx_idx, tx_idx, last_idx;
  logic [7:0]        rx_sr, tx_sr;
  logic              rx_par, tx_par, tx_line, rx_line;
  logic [15:0]       div_eff;

  function automatic urm_sel_t decode(input logic [2:0] a, input logic [7:0] lc,
                                      input logic en, input logic [7:0] mc);
    urm_sel_t s;
    s = SEL_NONE;
    if (lc == LCR_ENH_KEY) begin
      case (a)
        ADR_HOLD: s = SEL_DLL;
        ADR_IER:  s = SEL_DLH;
        ADR_FIFO: s = SEL_EFR;
        ADR_LCR:  s = SEL_LCR;
        ADR_MCR:  s = SEL_RESUME_CHAR_ONE;
        ADR_LSR:  s = SEL_RESUME_CHAR_TWO;
        ADR_MSR:  s = SEL_PAUSE_CHAR_ONE;
        default:  s = SEL_PAUSE_CHAR_TWO;
      endcase
    end else if (lc[LCR_DLAB]) begin
      case (a)
        ADR_HOLD: s = SEL_DLL;
        ADR_IER:  s = SEL_DLH;
        ADR_LCR:  s = SEL_LCR;
        default:  s = SEL_NONE;
      endcase
    end else begin
      case (a)
        ADR_HOLD: s = SEL_HOLD;
        ADR_IER:  s = SEL_IER;
        ADR_FIFO: s = SEL_FIFO;
        ADR_LCR:  s = SEL_LCR;
        ADR_MCR:  s = SEL_MCR;
        ADR_LSR:  s = SEL_LSR;
        ADR_MSR:  s = (en && mc[MCR_TCR]) ? SEL_TCR : SEL_MSR;
        default: begin
          if (en && mc[MCR_TCR]) s = SEL_TLR;
          else if (mc[MCR_RDY] && !mc[MCR_LOOP]) s = SEL_RDY;
          else s = SEL_SPR;
        end
      endcase
    end
    return s;
  endfunction : decode

  function automatic logic [7:0] enh_merge(input logic [7:0] old, input logic [7:0] nw,
                                           input logic [7:0] mask, input logic en);
    return en ? nw : ((nw & ~mask) | (old & mask));
  endfunction : enh_merge

  function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lc);
    return lc[LCR_STICK] ? !lc[LCR_EVEN] : ((^d) ^ !lc[LCR_EVEN]);
  endfunction : parity_of

  // host strobes act once per assertion
  assign rd_act  = !cs_n && !rd_n;
  assign wr_act  = !cs_n && !wr_n;
  assign rd_go   = rd_act && !rd_prev;
  assign wr_go   = wr_act && !wr_prev;
  assign enh_en  = enhanced_feature_control[EFR_ENH];
  assign sel     = decode(addr, line_format_control, enh_en, modem_control);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  // register writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      line_format_control <= REG_RST; ier <= REG_RST; fifo_control <= REG_RST; modem_control <= REG_RST; spr <= REG_RST;
      transmission_control <= REG_RST; trigger_level <= REG_RST; dll <= REG_RST; divisor_high_byte <= REG_RST; enhanced_feature_control <= REG_RST;
      resume_char_one <= REG_RST; resume_char_two <= REG_RST; pause_char_one <= REG_RST; pause_char_two <= REG_RST;
    end else if (wr_go) begin
      case (sel)
        SEL_LCR:   line_format_control <= data_in;
        SEL_IER:   ier <= enh_merge(ier, data_in, IER_ENH, enh_en);
        SEL_MCR:   modem_control <= enh_merge(modem_control, data_in, MCR_ENH, enh_en);
        SEL_FIFO:  fifo_control <= enh_merge(fifo_control, data_in, FCR_ENH, enh_en) & 8'hF9;
        SEL_SPR:   spr <= data_in;
        SEL_TCR:   transmission_control <= data_in;
        SEL_TLR:   trigger_level <= data_in;
        SEL_DLL:   dll <= data_in;
        SEL_DLH:   divisor_high_byte <= data_in;
        SEL_EFR:   enhanced_feature_control <= data_in;
        SEL_RESUME_CHAR_ONE:  resume_char_one <= data_in;
        SEL_RESUME_CHAR_TWO:  resume_char_two <= data_in;
        SEL_PAUSE_CHAR_ONE: pause_char_one <= data_in;
        SEL_PAUSE_CHAR_TWO: pause_char_two <= data_in;
        default: begin
        end
      endcase
    end
  end

  // fifo flush on reset bits or enable change
  assign rx_flush = wr_go && (sel == SEL_FIFO) &&
                    (data_in[FCR_RX_RST] || (data_in[FCR_EN] != fifo_control[FCR_EN]));
  assign tx_flush = wr_go && (sel == SEL_FIFO) &&
                    (data_in[FCR_TX_RST] || (data_in[FCR_EN] != fifo_control[FCR_EN]));

  // read mux
  assign lsr_val = {!rx_empty && (|rx_top[10:8]),
                    tx_empty && !sk_valid && (tx_state == SER_IDLE), tx_empty,
                    rx_top[10] && !rx_empty, rx_top[9] && !rx_empty, rx_top[8] && !rx_empty,
                    overrun, !rx_empty};

  always_comb begin
    case (sel)
      SEL_HOLD:  rd_val = rx_top[7:0];
      SEL_IER:   rd_val = ier;
      SEL_FIFO:  rd_val = {fifo_control[FCR_EN], fifo_control[FCR_EN], 2'b00, IIR_NONE};
      SEL_LCR:   rd_val = line_format_control;
      SEL_MCR:   rd_val = modem_control;
      SEL_LSR:   rd_val = lsr_val;
      SEL_SPR:   rd_val = spr;
      SEL_TCR:   rd_val = transmission_control;
      SEL_TLR:   rd_val = trigger_level;
      SEL_RDY:   rd_val = {3'b000, !rx_empty, 3'b000, !tx_full};
      SEL_DLL:   rd_val = dll;
      SEL_DLH:   rd_val = divisor_high_byte;
      SEL_EFR:   rd_val = enhanced_feature_control;
      SEL_RESUME_CHAR_ONE:  rd_val = resume_char_one;
      SEL_RESUME_CHAR_TWO:  rd_val = resume_char_two;
      SEL_PAUSE_CHAR_ONE: rd_val = pause_char_one;
      SEL_PAUSE_CHAR_TWO: rd_val = pause_char_two;
      default:   rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !rd_act;
      if (rd_go) data_out <= rd_val;
    end
  end

  // overrun flag, set wins over read clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) overrun <= 1'b0;
    else if (rx_push && rx_full) overrun <= 1'b1;
    else if (rd_go && (sel == SEL_LSR)) overrun <= 1'b0;
  end

  // bit timing from divisor, 16 clocks per divisor step
  assign div_eff  = ({divisor_high_byte, dll} == 16'h0000) ? DIV_MIN : {divisor_high_byte, dll};
  assign bit_len  = {1'b0, div_eff, 4'h0};
  assign half_len = {1'b0, bit_len[TICK_W-1:1]};
  assign last_idx = 3'(3'h4 + {1'b0, line_format_control[1:0]});
  assign stop_len = !line_format_control[LCR_STOP] ? bit_len :
                    (last_idx == 3'h4) ? TICK_W'(bit_len + half_len) : {bit_len[TICK_W-2:0], 1'b0};
  assign rx_line  = modem_control[MCR_LOOP] ? tx_line : rx_pin;

  // receive shifter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state <= SER_IDLE;
      rx_tick  <= '0;
      rx_idx   <= 3'h0;
      rx_sr    <= 8'h00;
      rx_par   <= 1'b0;
      rx_push  <= 1'b0;
      rx_word  <= '0;
    end else begin
      rx_push <= 1'b0;
      rx_tick <= TICK_W'(rx_tick + 1'b1);
      case (rx_state)
        SER_IDLE: begin
          rx_tick <= '0;
          if (!rx_line) begin
            rx_state <= SER_START;
            rx_sr    <= 8'h00;
            rx_idx   <= 3'h0;
          end
        end
        SER_START: begin
          if (rx_tick == half_len) begin
            rx_tick  <= '0;
            rx_state <= rx_line ? SER_IDLE : SER_DATA;
          end
        end
        SER_DATA: begin
          if (rx_tick == TICK_W'(bit_len - 1'b1)) begin
            rx_tick        <= '0;
            rx_sr[rx_idx]  <= rx_line;
            rx_idx         <= 3'(rx_idx + 3'h1);
            if (rx_idx == last_idx) rx_state <= line_format_control[LCR_PAR] ? SER_PARITY : SER_STOP;
          end
        end
        SER_PARITY: begin
          if (rx_tick == TICK_W'(bit_len - 1'b1)) begin
            rx_tick  <= '0;
            rx_par   <= rx_line;
            rx_state <= SER_STOP;
          end
        end
        SER_STOP: begin
          if (rx_tick == TICK_W'(bit_len - 1'b1)) begin
            rx_state <= SER_IDLE;
            rx_push  <= 1'b1;
            rx_word  <= {(rx_sr == 8'h00) && !rx_line && !(line_format_control[LCR_PAR] && rx_par),
                         !rx_line,
                         line_format_control[LCR_PAR] && (rx_par != parity_of(rx_sr, line_format_control)),
                         rx_sr};
          end
        end
        default: rx_state <= SER_IDLE;
      endcase
    end
  end

  assign rx_pop = rd_go && (sel == SEL_HOLD);

  urm_fifo #(.W(RX_W)) u_rx_fifo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .flush     (rx_flush),
    .single    (!fifo_control[FCR_EN]),
    .overwrite (1'b1),
    .push      (rx_push),
    .push_data (rx_word),
    .pop       (rx_pop),
    .pop_data  (rx_top),
    .empty     (rx_empty),
    .full      (rx_full),
    .count     (rx_count)
  );

  assign tx_push = wr_go && (sel == SEL_HOLD);
  assign tx_pop  = !tx_empty && sk_in_ready;

  urm_fifo #(.W(8)) u_tx_fifo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .flush     (tx_flush),
    .single    (!fifo_control[FCR_EN]),
    .overwrite (1'b0),
    .push      (tx_push),
    .push_data (data_in),
    .pop       (tx_pop),
    .pop_data  (tx_fifo_data),
    .empty     (tx_empty),
    .full      (tx_full),
    .count     (tx_count)
  );

  assign sk_ready = (tx_state == SER_IDLE);

  urm_skid u_tx_skid (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_valid  (tx_pop),
    .in_ready  (sk_in_ready),
    .in_data   (tx_fifo_data),
    .out_valid (sk_valid),
    .out_ready (sk_ready),
    .out_data  (sk_data)
  );

  // transmit shifter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state <= SER_IDLE;
      tx_tick  <= '0;
      tx_idx   <= 3'h0;
      tx_sr    <= 8'h00;
      tx_par   <= 1'b0;
      tx_line  <= 1'b1;
    end else begin
      tx_tick <= TICK_W'(tx_tick + 1'b1);
      case (tx_state)
        SER_IDLE: begin
          tx_tick <= '0;
          tx_line <= 1'b1;
          if (sk_valid) begin
            tx_state <= SER_START;
            tx_sr    <= sk_data;
            tx_par   <= parity_of(sk_data, line_format_control);
            tx_line  <= 1'b0;
            tx_idx   <= 3'h0;
          end
        end
        SER_START: begin
          if (tx_tick == TICK_W'(bit_len - 1'b1)) begin
            tx_tick  <= '0;
            tx_state <= SER_DATA;
            tx_line  <= tx_sr[0];
          end
        end
        SER_DATA: begin
          if (tx_tick == TICK_W'(bit_len - 1'b1)) begin
            tx_tick <= '0;
            tx_sr   <= {1'b0, tx_sr[7:1]};
            tx_idx  <= 3'(tx_idx + 3'h1);
            if (tx_idx == last_idx) begin
              tx_state <= line_format_control[LCR_PAR] ? SER_PARITY : SER_STOP;
              tx_line  <= line_format_control[LCR_PAR] ? tx_par : 1'b1;
            end else begin
              tx_line <= tx_sr[1];
            end
          end
        end
        SER_PARITY: begin
          if (tx_tick == TICK_W'(bit_len - 1'b1)) begin
            tx_tick  <= '0;
            tx_state <= SER_STOP;
            tx_line  <= 1'b1;
          end
        end
        SER_STOP: begin
          if (tx_tick == TICK_W'(stop_len - 1'b1)) tx_state <= SER_IDLE;
        end
        default: tx_state <= SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) tx_pin <= 1'b1;
    else tx_pin <= modem_control[MCR_LOOP] | (tx_line & !line_format_control[LCR_BREAK]);
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_general_bank: assert property (sel == SEL_HOLD |-> !line_format_control[LCR_DLAB])
    else $error("general bank decoded with divisor latch enabled");
  a_divisor_write: assert property (wr_go && sel == SEL_DLL |=> dll == $past(data_in))
    else $error("divisor low byte not written in special bank");
  a_enh_key: assert property (sel == SEL_EFR || sel == SEL_PAUSE_CHAR_TWO |-> line_format_control == LCR_ENH_KEY)
    else $error("enhanced bank decoded without key value");
  a_enh_gate: assert property (wr_go && sel == SEL_IER && !enh_en |=>
                               ier[7:4] == $past(ier[7:4]))
    else $error("enhanced interrupt bits changed while locked");
  a_rx_single: assert property (!fifo_control[FCR_EN] |-> rx_count <= 7'h01)
    else $error("receive storage grew past entry zero while disabled");
  a_rx_drop: assert property (rx_push && rx_full && fifo_control[FCR_EN] && !rx_pop && !rx_flush
                              |=> rx_count == FIFO_FULL && overrun)
    else $error("full receive fifo did not drop and flag");
  a_tx_drop: assert property (tx_push && tx_full && !tx_pop && !tx_flush |=>
                              tx_count == $past(tx_count))
    else $error("write into full transmit storage changed its count");
  a_tx_single: assert property (!fifo_control[FCR_EN] |-> tx_count <= 7'h01)
    else $error("transmit storage grew past one entry while disabled");
  a_tcr_gate: assert property (sel == SEL_TCR |-> enh_en && modem_control[MCR_TCR])
    else $error("transmission control decoded without enables");
  a_rdy_gate: assert property (sel == SEL_RDY |-> modem_control[MCR_RDY] && !modem_control[MCR_LOOP])
    else $error("ready summary decoded without enable");
  a_rdy_bits: assert property (rd_go && sel == SEL_RDY |=>
                               data_out == {3'b000, !$past(rx_empty), 3'b000, !$past(tx_full)})
    else $error("ready summary bits wrong");
  a_tx_start: assert property (tx_state == SER_IDLE && sk_valid |=>
                               tx_state == SER_START && !tx_line)
    else $error("pending byte did not start transmission");
endmodule : urm_top

// ===== verif/urm_host.sv
// host processor model driving the channel's parallel register bus
module urm_host (
  input  wire logic       mclk,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [2:0] addr,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
  end

  // one write cycle, strobe released for a cycle after
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    data_in = d;
    @(negedge mclk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    data_in = ~d;
    @(negedge mclk);
  endtask : wr

  // read held until the registered answer has landed
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge mclk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    repeat (2) @(negedge mclk);
    d = data_out;
    cs_n = 1'b1;
    rd_n = 1'b1;
    @(negedge mclk);
  endtask : rd
endmodule : urm_host

// ===== verif/tb.sv
// register bank, receive and transmit fifo tests of one channel
module tb
  import urm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk;
  logic       arst_n;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [2:0] addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe_n;
  logic       rx_pin;
  logic       tx_pin;
  int         err_count;
  int         samples_checked;

  urm_top u_dut (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .rx_pin(rx_pin), .tx_pin(tx_pin));

  urm_host u_host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
    logic [7:0] g;
    u_host.rd(a, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
    samples_checked++;
    if (data_oe_n !== 1'b1) begin
      err_count++;
      $display("Error data_oe_n after %s expected 1 seen %b", n, data_oe_n);
    end
  endtask : rc

  // one 8n1 character at 16 cycles a bit, stop level chosen
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int b = 0; b < 10; b++) begin
      @(negedge mclk);
      rx_pin = f[b];
      repeat (15) @(negedge mclk);
    end
    @(negedge mclk);
    rx_pin = 1'b1;
    repeat (31) @(negedge mclk);
  endtask : send

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200us;
    err_count++;
    wrap_up();
  end

  initial begin
    err_count = 0;
    samples_checked = 0;
    rx_pin = 1'b1;
    arst_n = 1'b0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    rc(ADR_LCR, 8'h00, "lcr reset");
    rc(ADR_FIFO, 8'h01, "iir fifo off");
    u_host.wr(ADR_MCR, 8'hE0);
    rc(ADR_MCR, 8'h00, "mcr locked");
    u_host.wr(ADR_SPR, 8'h5A);
    u_host.wr(ADR_LCR, 8'h80);
    u_host.wr(ADR_HOLD, 8'h01);
    u_host.wr(ADR_IER, 8'h00);
    rc(ADR_HOLD, 8'h01, "div low");
    rc(ADR_SPR, 8'h00, "spr hidden");
    u_host.wr(ADR_LCR, LCR_ENH_KEY);
    u_host.wr(ADR_FIFO, 8'h10);
    u_host.wr(ADR_MCR, 8'hA5);
    rc(ADR_FIFO, 8'h10, "efr");
    rc(ADR_MCR, 8'hA5, "resume one");
    u_host.wr(ADR_LCR, 8'h03);
    rc(ADR_SPR, 8'h5A, "spr");
    u_host.wr(ADR_MCR, 8'h44);
    u_host.wr(ADR_SPR, 8'h3C);
    rc(ADR_SPR, 8'h3C, "trigger level");
    u_host.wr(ADR_MCR, 8'h04);
    rc(ADR_SPR, 8'h01, "ready summary");
    u_host.wr(ADR_MCR, 8'h00);
    send(8'h41, 1'b1);
    send(8'h42, 1'b1);
    rc(ADR_HOLD, 8'h42, "rx overwrite");
    u_host.wr(ADR_MCR, 8'h10);
    u_host.wr(ADR_HOLD, 8'hC3);
    repeat (130) @(negedge mclk);
    samples_checked++;
    if (tx_pin !== 1'b1) begin
      err_count++;
      $display("Error tx_pin in loopback expected 1 seen %b", tx_pin);
    end
    repeat (130) @(negedge mclk);
    rc(ADR_HOLD, 8'hC3, "loopback");
    u_host.wr(ADR_MCR, 8'h00);
    u_host.wr(ADR_FIFO, 8'h01);
    for (int i = 0; i < 66; i++) send(8'(i), 1'b1);
    for (int i = 0; i < 64; i++) rc(ADR_HOLD, 8'(i), "rx fifo");
    rc(ADR_LSR, 8'h62, "lsr overrun");
    send(8'h55, 1'b0);
    rc(ADR_LSR, 8'hE9, "lsr framing");
    rc(ADR_HOLD, 8'h55, "bad char");
    rc(ADR_LSR, 8'h60, "lsr clear");
    u_host.wr(ADR_MCR, 8'h04);
    for (int i = 0; i < 72; i++) u_host.wr(ADR_HOLD, 8'(i));
    rc(ADR_SPR, 8'h00, "tx full summary");
    rc(ADR_LSR, 8'h00, "tx busy status");
    wrap_up();
  end
endmodule : tb
